// *** core/pcc_map.svh ***
// addresses, field positions, reset values and timing of the cross check outputs
// assumes a 32-bit word register port with byte addresses
`ifndef PCC_MAP_SVH
`define PCC_MAP_SVH
// register byte addresses
`define PCC_A_CTRL 8'h00
`define PCC_A_OFFS 8'h04
`define PCC_A_TOL1 8'h08
`define PCC_A_TOL2 8'h0c
`define PCC_A_TOL3 8'h10
`define PCC_A_WARN 8'h14
`define PCC_A_STATE 8'h18
`define PCC_A_DEV 8'h1c
`define PCC_A_ISTAT 8'h20
`define PCC_A_IMASK 8'h24
// control fields
`define PCC_F_MODE 1:0
`define PCC_F_DLY1 6:4
`define PCC_F_DLY2 10:8
`define PCC_CTRL_RST 32'h0000_0000
`define PCC_TOL_RST 32'h0000_0000
// event bits
`define PCC_EV_FAIL 0
`define PCC_EV_WARN 1
`define PCC_EV_RECOV 2
`define PCC_EV_W 3
// timing
`define PCC_CLK_MHZ 200
`define PCC_CYCLE_US 4000
`define PCC_RECOV_MS 1000
`endif

// *** core/pcc_pkg.sv ***
// types shared by the cross check output stage
// assumes pcc_map.svh for all numbers
package pcc_pkg;
  // one motion record
  typedef struct packed {
    logic signed [31:0] abs_pos;
    logic signed [31:0] rel_pos;
    logic signed [15:0] speed;
    logic abs_valid;
    logic rel_valid;
    logic abs_reliable;
    logic rel_reliable;
    logic spd_reliable;
  } motion_t;
  // comparison mode
  typedef enum logic [1:0] {MODE_OFF = 2'h0, MODE_SAME = 2'h1, MODE_OPP = 2'h2,
    MODE_REL = 2'h3} mode_t;
  // run sequencing, gray along idle-init-run
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_INIT = 2'h1, ST_RUN = 2'h3} run_st_t;
endpackage

// *** core/motion_if.sv ***
// carrier for one motion record between the output stage and its delay line
// assumes pcc_pkg compiled before
`timescale 1ns/10ps
interface motion_if;
  import pcc_pkg::*;
  motion_t rec; // the record
  modport source (output rec);
  modport sink (input rec);
endinterface

// *** core/motion_delay.sv ***
// programmable delay line for one motion record, stepped once per logic cycle
// assumes step is a one-cycle enable pulse
`timescale 1ns/10ps
module motion_delay #(
  parameter int DEPTH = 7
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic step,
  input wire logic flush,
  input wire logic [2:0] sel,
  input pcc_pkg::motion_t din,
  motion_if.source dout
);
  import pcc_pkg::*;
  motion_t line_r [DEPTH]; // stages
  // ---------------------------------------------
  // shift stages on each logic cycle
  // ---------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < DEPTH; i++) line_r[i] <= '0;
    end
    else if (flush)
    begin
      for (int i = 0; i < DEPTH; i++) line_r[i] <= '0;
    end
    else if (step)
    begin
      line_r[0] <= din;
      for (int i = 1; i < DEPTH; i++) line_r[i] <= line_r[i-1];
    end
  end
  // zero selects the live record
  assign dout.rec = (sel == 3'h0) ? din : line_r[int'(sel) - 1];
endmodule // motion_delay

// *** core/dual_encoder_compare_outputs.sv ***
// output stage of a two-source position cross check
// assumes records synchronous to clk and a run level from the controller
// Functional notes
// - forward first record if valid, else second
// - reliability flags follow cross check result
// - configurable delay of the forwarded values
// - status low when deviation exceeds tolerance
// - status back high after one second
// - invalid relative position forces status high
// - run entry sets status and warning high
// - check done rises on first comparison
// - check done low while relative invalid
// - reset possible output shows acceptance
// - warning low when deviation exceeds limit
// - warning high again without delay
// - absolute pass marks all reliable, relative two
// - reset acts on rising edge only
// - tolerance two or three when enabled
// - inhibit suppresses failure diagnostic event
`include "pcc_map.svh"
`timescale 1ns/10ps
module dual_encoder_compare_outputs #(
  parameter int DLY_DEPTH = 7,
  parameter int CYCLE_CLKS = `PCC_CYCLE_US * `PCC_CLK_MHZ,
  parameter int RECOV_CLKS = `PCC_RECOV_MS * 1000 * `PCC_CLK_MHZ
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input pcc_pkg::motion_t mot_in1,
  input pcc_pkg::motion_t mot_in2,
  input wire logic inhibit_err,
  input wire logic reset_req,
  input wire logic tol2_en,
  input wire logic tol3_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output pcc_pkg::motion_t mot_out,
  output logic cmp_status,
  output logic warn_status,
  output logic check_done,
  output logic reset_possible,
  output logic irq
);
  import pcc_pkg::*;
  localparam logic [31:0] CYC_LAST = 32'(CYCLE_CLKS - 1);
  localparam logic [31:0] REC_LAST = 32'(RECOV_CLKS - 1);
  // ---------------------------------------------
  // registers and state
  // ---------------------------------------------
  logic [31:0] ctrl_r; // mode and delays
  logic [31:0] offs_r; // constant difference or total
  logic [31:0] tol1_r; // permanent tolerance
  logic [31:0] tol2_r; // first increased tolerance
  logic [31:0] tol3_r; // second increased tolerance
  logic [31:0] warn_r; // warning limit
  logic [`PCC_EV_W-1:0] istat_r; // sticky events
  logic [`PCC_EV_W-1:0] istat_nxt;
  logic [`PCC_EV_W-1:0] imask_r; // event mask
  logic [31:0] cyc_cnt_r; // logic cycle divider
  logic [31:0] rec_cnt_r; // recovery timer
  logic signed [31:0] rel_base_r; // relative reference
  logic in_tol_r; // last deviation within tolerance
  logic rst_req_r; // previous reset request
  run_st_t st_r;
  run_st_t st_nxt;
  logic [31:0] dev_r; // last deviation
  // ---------------------------------------------
  // logic cycle and run sequencing
  // ---------------------------------------------
  wire cycle_en = (cyc_cnt_r == CYC_LAST);
  wire run_entry = (st_r == ST_INIT);
  wire running = (st_r == ST_RUN);
  // divider for the logic cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cyc_cnt_r <= 32'h0;
    else
      cyc_cnt_r <= cycle_en ? 32'h0 : cyc_cnt_r + 32'h1;
  end
  // idle until run, one init cycle on entry
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: st_nxt = run ? ST_INIT : ST_IDLE;
      ST_INIT: st_nxt = run ? ST_RUN : ST_IDLE;
      ST_RUN: st_nxt = run ? ST_RUN : ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end
  // state register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= ST_IDLE;
    else
      st_r <= st_nxt;
  end
  // ---------------------------------------------
  // input delay
  // ---------------------------------------------
  motion_if m1_if ();
  motion_if m2_if ();
  motion_delay #(.DEPTH(DLY_DEPTH)) u_dly1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .step(cycle_en),
    .flush(run_entry),
    .sel(ctrl_r[`PCC_F_DLY1]),
    .din(mot_in1),
    .dout(m1_if.source)
  );
  motion_delay #(.DEPTH(DLY_DEPTH)) u_dly2 (
    .clk(clk),
    .sys_rst(sys_rst),
    .step(cycle_en),
    .flush(run_entry),
    .sel(ctrl_r[`PCC_F_DLY2]),
    .din(mot_in2),
    .dout(m2_if.source)
  );
  wire motion_t m1 = m1_if.rec;
  wire motion_t m2 = m2_if.rec;
  // ---------------------------------------------
  // comparison
  // ---------------------------------------------
  wire mode_t mode = mode_t'(ctrl_r[`PCC_F_MODE]);
  wire both_rel = m1.rel_valid && m2.rel_valid;
  wire abs_mode = (mode == MODE_SAME) || (mode == MODE_OPP);
  // absolute check needs both absolute positions
  wire abs_chk = abs_mode && m1.abs_valid && m2.abs_valid && both_rel;
  // relative check when absolute cannot run
  wire rel_chk = (mode != MODE_OFF) && both_rel && !abs_chk;
  wire cmp_run = abs_chk || rel_chk;
  // difference or total against the constant
  wire signed [31:0] abs_raw = (mode == MODE_OPP) ? (m1.abs_pos + m2.abs_pos - offs_r)
    : (m1.abs_pos - m2.abs_pos - offs_r);
  wire signed [31:0] rel_diff = (mode == MODE_OPP) ? (m1.rel_pos + m2.rel_pos)
    : (m1.rel_pos - m2.rel_pos);
  // first check after a gap rebases, so it never sees a stale reference
  wire signed [31:0] rel_raw = check_done ? (rel_diff - rel_base_r) : 32'sh0;
  wire signed [31:0] dev_raw = abs_chk ? abs_raw : rel_raw;
  wire [31:0] dev = dev_raw[31] ? 32'(-dev_raw) : dev_raw;
  // tolerance selection
  wire [31:0] tol = tol3_en ? tol3_r : (tol2_en ? tol2_r : tol1_r);
  wire over_tol = dev > tol;
  wire over_warn = dev > warn_r;
  // fresh rising edge of the reset request
  wire rst_edge = reset_req && !rst_req_r;
  wire rst_act = rst_edge && reset_possible;
  wire eval = running && cycle_en && cmp_run;
  // acceptance of a reset: comparison live
  assign reset_possible = running && both_rel && (mode != MODE_OFF);
  // ---------------------------------------------
  // status outputs
  // ---------------------------------------------
  // fault status with recovery delay
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cmp_status <= 1'b1;
      rec_cnt_r <= 32'h0;
      in_tol_r <= 1'b1;
    end
    else if (run_entry || rst_act || (running && cycle_en && !both_rel))
    begin
      cmp_status <= 1'b1;
      rec_cnt_r <= 32'h0;
      in_tol_r <= 1'b1;
    end
    else if (eval && over_tol)
    begin
      cmp_status <= 1'b0;
      rec_cnt_r <= 32'h0;
      in_tol_r <= 1'b0;
    end
    else
    begin
      if (eval)
        in_tol_r <= 1'b1;
      // count while back in tolerance
      if (!cmp_status && (in_tol_r || eval))
      begin
        if (rec_cnt_r == REC_LAST)
        begin
          cmp_status <= 1'b1;
          rec_cnt_r <= 32'h0;
        end
        else
          rec_cnt_r <= rec_cnt_r + 32'h1;
      end
    end
  end
  // warning status, no delay on return
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      warn_status <= 1'b1;
    else if (run_entry)
      warn_status <= 1'b1;
    else if (eval)
      warn_status <= !over_warn;
  end
  // comparison done flag
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      check_done <= 1'b0;
    else if (!running)
      check_done <= 1'b0;
    else if (cycle_en && !both_rel)
      check_done <= 1'b0;
    else if (eval)
      check_done <= 1'b1;
  end
  // relative reference, rebased on first check and on reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rel_base_r <= 32'sh0;
    else if (rst_act || (eval && !check_done))
      rel_base_r <= rel_diff;
  end
  // reset request edge memory and last deviation
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rst_req_r <= 1'b0;
      dev_r <= 32'h0;
    end
    else
    begin
      rst_req_r <= reset_req;
      if (eval)
        dev_r <= dev;
    end
  end
  // ---------------------------------------------
  // forwarded record
  // ---------------------------------------------
  wire motion_t fwd = m1.rel_valid ? m1 : m2;
  wire abs_pass = abs_chk && !over_tol;
  wire any_pass = cmp_run && !over_tol;
  // record with reliability from the check
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      mot_out <= '0;
    else if (!running)
      mot_out <= '0;
    else if (cycle_en)
    begin
      mot_out <= fwd;
      mot_out.abs_reliable <= abs_pass;
      mot_out.rel_reliable <= any_pass;
      mot_out.spd_reliable <= any_pass;
    end
  end
  // ---------------------------------------------
  // register port
  // ---------------------------------------------
  wire rd_istat = reg_rd && (reg_addr == `PCC_A_ISTAT);
  wire ev_fail = eval && over_tol && !inhibit_err;
  wire ev_warn = eval && over_warn && warn_status;
  wire ev_recov = running && !cmp_status && (rec_cnt_r == REC_LAST);
  wire [`PCC_EV_W-1:0] ev_vec = {ev_recov, ev_warn, ev_fail};
  wire [31:0] state_word = {28'h0, reset_possible, check_done, warn_status, cmp_status};
  // events win over the read clear
  assign istat_nxt = (rd_istat ? '0 : istat_r) | ev_vec;
  assign irq = |(istat_r & imask_r);
  // writes
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_r <= `PCC_CTRL_RST;
      offs_r <= `PCC_TOL_RST;
      tol1_r <= `PCC_TOL_RST;
      tol2_r <= `PCC_TOL_RST;
      tol3_r <= `PCC_TOL_RST;
      warn_r <= `PCC_TOL_RST;
      imask_r <= '0;
      istat_r <= '0;
    end
    else
    begin
      istat_r <= istat_nxt;
      if (reg_wr && reg_addr == `PCC_A_CTRL)
        ctrl_r <= reg_wdata;
      else if (reg_wr && reg_addr == `PCC_A_OFFS)
        offs_r <= reg_wdata;
      else if (reg_wr && reg_addr == `PCC_A_TOL1)
        tol1_r <= reg_wdata;
      else if (reg_wr && reg_addr == `PCC_A_TOL2)
        tol2_r <= reg_wdata;
      else if (reg_wr && reg_addr == `PCC_A_TOL3)
        tol3_r <= reg_wdata;
      else if (reg_wr && reg_addr == `PCC_A_WARN)
        warn_r <= reg_wdata;
      else if (reg_wr && reg_addr == `PCC_A_IMASK)
        imask_r <= reg_wdata[`PCC_EV_W-1:0];
    end
  end
  // read mux, unmapped reads zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    if (reg_addr == `PCC_A_CTRL) rd_mux = ctrl_r;
    else if (reg_addr == `PCC_A_OFFS) rd_mux = offs_r;
    else if (reg_addr == `PCC_A_TOL1) rd_mux = tol1_r;
    else if (reg_addr == `PCC_A_TOL2) rd_mux = tol2_r;
    else if (reg_addr == `PCC_A_TOL3) rd_mux = tol3_r;
    else if (reg_addr == `PCC_A_WARN) rd_mux = warn_r;
    else if (reg_addr == `PCC_A_STATE) rd_mux = state_word;
    else if (reg_addr == `PCC_A_DEV) rd_mux = dev_r;
    else if (reg_addr == `PCC_A_ISTAT) rd_mux = {29'h0, istat_r};
    else if (reg_addr == `PCC_A_IMASK) rd_mux = {29'h0, imask_r};
  end
  // read data one cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end
  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_fwd_first: assert property (
    running && cycle_en && m1.rel_valid |=> mot_out.rel_pos == $past(m1.rel_pos))
    else $error("forwarded record not from first input");
  chk_fault_drop: assert property (
    eval && over_tol && !rst_act |=> !cmp_status)
    else $error("status not low on excess deviation");
  chk_recov_time: assert property (
    $rose(cmp_status) |-> $past(rec_cnt_r) == REC_LAST || $past(run_entry)
      || $past(rst_act) || $past(!both_rel))
    else $error("status returned before recovery time");
  chk_invalid_ok: assert property (
    running && cycle_en && !both_rel |=> cmp_status && !check_done)
    else $error("invalid input did not force status high");
  chk_run_init: assert property (
    run_entry |=> cmp_status && warn_status && !check_done)
    else $error("run entry did not initialise outputs");
  chk_done_set: assert property (
    eval |=> check_done)
    else $error("check done not raised");
  chk_warn_track: assert property (
    eval && !run_entry |=> warn_status == !$past(over_warn))
    else $error("warning status does not follow limit");
  chk_rel_flags: assert property (
    running && cycle_en && rel_chk && !over_tol |=> mot_out.rel_reliable
      && mot_out.spd_reliable && !mot_out.abs_reliable)
    else $error("relative pass flags wrong");
  chk_inhibit_diag: assert property (
    inhibit_err && eval |=> !istat_r[`PCC_EV_FAIL] || $past(istat_r[`PCC_EV_FAIL]))
    else $error("failure event logged while inhibited");
endmodule // dual_encoder_compare_outputs

// *** test/enc_src_model.sv ***
// behavioural model of one upstream motion source for the cross check bench
// assumes the bench moves its knobs right after a rising edge
`timescale 1ns/10ps
module enc_src_model (
  input wire logic clk,
  input wire logic [31:0] pos,
  input wire logic abs_ok,
  input wire logic rel_ok,
  output pcc_pkg::motion_t rec
);
  import pcc_pkg::*;
  // -------------------------------------------
  // record publishing
  // -------------------------------------------
  // one record a clock; an invalid field churns so stale values never pass
  always_ff @(posedge clk)
  begin
    rec.abs_pos <= abs_ok ? pos : ~rec.abs_pos;
    rec.rel_pos <= rel_ok ? pos : ~rec.rel_pos;
    rec.speed <= pos[15:0];
    rec.abs_valid <= abs_ok;
    rec.rel_valid <= rel_ok;
    rec.abs_reliable <= 1'b0; // reliability is the checker's to set
    rec.rel_reliable <= 1'b0;
    rec.spd_reliable <= 1'b0;
  end
endmodule // enc_src_model

// *** test/tb_dual_encoder_compare_outputs.sv ***
// self-checking bench for the cross check output stage
// assumes a logic cycle of 8 clocks and a recovery time of 50 clocks
`timescale 1ns/10ps
`include "pcc_map.svh"
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t %s", $time, m); end end
module tb_dual_encoder_compare_outputs;
  import pcc_pkg::*;
  localparam int LC = 8; // logic cycle in clocks
  localparam int TOL1 = 10; // permanent tolerance
  localparam int WARN = 5; // warning threshold
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic run = 1'b0;
  logic inhibit_err = 1'b0;
  logic reset_req = 1'b0;
  logic tol2_en = 1'b0;
  logic tol3_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] p1 = 32'h0; // source positions
  logic [31:0] p2 = 32'h0;
  logic v1r = 1'b1; // relative validity per source
  logic v2r = 1'b1;
  logic [31:0] reg_rdata;
  logic [31:0] d;
  logic [31:0] p;
  logic [31:0] q;
  motion_t in1;
  motion_t in2;
  motion_t mot_out;
  logic cmp_status;
  logic warn_status;
  logic check_done;
  logic reset_possible;
  logic irq;
  int checked = 0;
  int n_fail = 0;
  int devs [4] = '{7, 5, 10, 11}; // deviations around both limits
  // -------------------------------------------
  // clock, sources and device
  // -------------------------------------------
  always #2.5 clk = ~clk;
  enc_src_model src1_u (.clk(clk), .pos(p1), .abs_ok(1'b1), .rel_ok(v1r), .rec(in1));
  enc_src_model src2_u (.clk(clk), .pos(p2), .abs_ok(1'b1), .rel_ok(v2r), .rec(in2));
  dual_encoder_compare_outputs #(.CYCLE_CLKS(LC), .RECOV_CLKS(50)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .run(run), .mot_in1(in1), .mot_in2(in2),
    .inhibit_err(inhibit_err), .reset_req(reset_req), .tol2_en(tol2_en),
    .tol3_en(tol3_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mot_out(mot_out), .cmp_status(cmp_status),
    .warn_status(warn_status), .check_done(check_done), .reset_possible(reset_possible),
    .irq(irq));
  // -------------------------------------------
  // expectations and bus tasks
  // -------------------------------------------
  // reliability bits {abs, rel, speed} for a passing record per mode
  function automatic logic [2:0] exp_rel(input int m);
    return (m == 1 || m == 2) ? 3'h7 : ((m == 3) ? 3'h3 : 3'h0);
  endfunction
  // deviation within a limit
  function automatic logic in_lim(input int dev, input int lim);
    return dev <= lim;
  endfunction
  // one write cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // one read cycle, data taken in the cycle after
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  // n logic cycles plus margin, ends mid cycle
  task automatic lcs(input int n);
    repeat (n * LC + 2) @(posedge clk);
    @(negedge clk);
  endtask
  // end of test line
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  // counts and verdict
  task automatic print_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // -------------------------------------------
  // main sequence
  // -------------------------------------------
  initial
  begin
    void'($urandom(12759));
    p = 32'h0000_1000 + ($urandom & 32'h0000_ffff);
    q = p + 32'h0000_0200 + ($urandom & 32'h0000_00ff);
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    `CHK(cmp_status, 1'b1, "reset status")
    `CHK(warn_status, 1'b1, "reset warn")
    `CHK(check_done, 1'b0, "reset done")
    rd(`PCC_A_CTRL, d);
    `CHK(d, `PCC_CTRL_RST, "ctrl reset")
    wr(`PCC_A_CTRL, 32'h1);
    wr(`PCC_A_TOL1, 32'(TOL1));
    wr(`PCC_A_TOL2, 32'h14);
    wr(`PCC_A_TOL3, 32'h1e);
    wr(`PCC_A_WARN, 32'(WARN));
    wr(`PCC_A_IMASK, 32'h0);
    rd(`PCC_A_TOL2, d);
    `CHK(d, 32'h14, "tol2 readback")
    rd(8'h30, d);
    `CHK(d, 32'h0, "unmapped read")
    done("registers");
    @(posedge clk);
    run <= 1'b1;
    p1 <= p;
    p2 <= p;
    for (int i = 0; i < 40 && check_done !== 1'b1; i++)
      @(negedge clk);
    if (check_done !== 1'b1)
    begin
      n_fail++;
      print_verdict();
    end
    lcs(1);
    `CHK(mot_out.abs_pos, p, "forward first")
    `CHK({mot_out.abs_reliable, mot_out.rel_reliable, mot_out.spd_reliable}, exp_rel(1), "rel")
    `CHK(reset_possible, 1'b1, "reset possible")
    done("first check");
    foreach (devs[i])
    begin
      @(posedge clk);
      p2 <= p + devs[i];
      lcs(2);
      `CHK(warn_status, in_lim(devs[i], WARN), "warn level")
      `CHK(cmp_status, in_lim(devs[i], TOL1), "status level")
      `CHK(mot_out.abs_reliable, in_lim(devs[i], TOL1), "abs reliable")
    end
    `CHK(irq, 1'b0, "masked irq")
    wr(`PCC_A_IMASK, 32'h7);
    @(negedge clk);
    `CHK(irq, 1'b1, "unmasked irq")
    rd(`PCC_A_ISTAT, d);
    `CHK(d[`PCC_EV_FAIL], 1'b1, "fail event")
    `CHK(irq, 1'b0, "irq cleared")
    done("limits");
    @(posedge clk);
    p2 <= p + 25;
    tol2_en <= 1'b1;
    lcs(10);
    `CHK(cmp_status, 1'b0, "tol2 exceeded")
    @(posedge clk);
    tol3_en <= 1'b1;
    lcs(2);
    `CHK(cmp_status, 1'b0, "recovery pending")
    lcs(8);
    `CHK(cmp_status, 1'b1, "recovered")
    rd(`PCC_A_ISTAT, d);
    `CHK(d[`PCC_EV_RECOV], 1'b1, "recovery event")
    @(posedge clk);
    tol2_en <= 1'b0;
    tol3_en <= 1'b0;
    lcs(2);
    `CHK(cmp_status, 1'b0, "tol1 again")
    @(posedge clk);
    v2r <= 1'b0;
    lcs(2);
    `CHK(cmp_status, 1'b1, "invalid status")
    `CHK(check_done, 1'b0, "invalid done")
    `CHK(reset_possible, 1'b0, "no reset")
    `CHK(mot_out.abs_pos, p, "first kept")
    @(posedge clk);
    v1r <= 1'b0;
    lcs(2);
    `CHK(mot_out.abs_pos, p + 25, "second taken")
    @(posedge clk);
    v1r <= 1'b1;
    v2r <= 1'b1;
    done("tolerance and validity");
    wr(`PCC_A_CTRL, 32'h3);
    @(posedge clk);
    p2 <= p + 75;
    lcs(2);
    `CHK(cmp_status, 1'b0, "rel fault")
    @(posedge clk);
    reset_req <= 1'b1;
    lcs(2);
    `CHK(cmp_status, 1'b1, "reset edge")
    @(posedge clk);
    p2 <= p + 100;
    lcs(2);
    `CHK(cmp_status, 1'b0, "level not edge")
    rd(`PCC_A_ISTAT, d);
    @(posedge clk);
    reset_req <= 1'b0;
    inhibit_err <= 1'b1;
    @(posedge clk);
    reset_req <= 1'b1;
    lcs(2);
    @(posedge clk);
    p2 <= p + 125;
    lcs(2);
    rd(`PCC_A_ISTAT, d);
    `CHK(d[`PCC_EV_FAIL], 1'b0, "inhibited event")
    `CHK(cmp_status, 1'b0, "inhibited fault")
    @(posedge clk);
    inhibit_err <= 1'b0;
    done("reset and inhibit");
    wr(`PCC_A_CTRL, 32'h221);
    @(posedge clk);
    p1 <= q;
    p2 <= q;
    lcs(4);
    @(posedge clk);
    p1 <= q + 8;
    p2 <= q + 8;
    lcs(1);
    `CHK(mot_out.abs_pos, q, "delayed old")
    lcs(4);
    `CHK(mot_out.abs_pos, q + 8, "delayed new")
    done("delay");
    for (int m = 0; m < 4; m++)
    begin
      wr(`PCC_A_CTRL, 32'(m));
      @(posedge clk);
      p1 <= p;
      p2 <= (m == 2) ? -p : p;
      reset_req <= 1'b0;
      lcs(2);
      @(posedge clk);
      reset_req <= 1'b1;
      lcs(2);
      `CHK({mot_out.abs_reliable, mot_out.rel_reliable, mot_out.spd_reliable}, exp_rel(m), "mode")
      `CHK(reset_possible, 1'(m != 0), "mode reset")
    end
    done("modes");
    wr(`PCC_A_CTRL, 32'h1);
    @(posedge clk);
    p2 <= p + 25;
    lcs(2);
    `CHK(warn_status, 1'b0, "warn before init")
    rd(`PCC_A_DEV, d);
    `CHK(d, 32'h0000_0019, "last deviation")
    rd(`PCC_A_STATE, d);
    `CHK(d, 32'h0000_000c, "state word")
    @(posedge clk);
    run <= 1'b0;
    @(posedge clk);
    run <= 1'b1;
    // idle edge, then the init edge re-initialises the outputs
    @(negedge clk);
    @(negedge clk);
    @(negedge clk);
    `CHK(cmp_status, 1'b1, "init status")
    `CHK(warn_status, 1'b1, "init warn")
    done("run entry");
    print_verdict();
  end
endmodule // tb_dual_encoder_compare_outputs
